// ==== include/mdu_pkg.sv ====
// Package for the multiply/divide unit: opcodes, latencies, carrier types.
// Assumes a single core clock and a synchronous active-high reset.
package mdu_pkg;
  localparam int unsigned MDU_W = 32;
  localparam int unsigned MDU_HALF = 16;
  localparam int unsigned MDU_CNT_W = 6;
  // Divide early-in skips
  localparam logic [5:0] MDU_SKIP_8 = 6'h17;
  localparam logic [5:0] MDU_SKIP_16 = 6'h0f;
  localparam logic [5:0] MDU_SKIP_24 = 6'h07;
  localparam logic [5:0] MDU_SKIP_32 = 6'h00;
  localparam logic [5:0] MDU_DIV_ITERS = 6'h20;
  // Fixed result stages
  localparam logic [5:0] MDU_CNT_ZERO = 6'h00;
  localparam logic [5:0] MDU_CNT_ONE = 6'h01;
  localparam logic [31:0] MDU_ZERO32 = 32'h0000_0000;
  localparam logic [63:0] MDU_ZERO64 = 64'h0;

  typedef enum logic [2:0] {
    MDU_OP_WMUL,
    MDU_OP_MACC_ADD,
    MDU_OP_MACC_SUB,
    MDU_OP_MUL_GPR,
    MDU_OP_DIV
  } mdu_op_t;

  typedef struct packed {
    logic valid;
    mdu_op_t op;
    logic is_signed;
    logic [31:0] first_source_operand;
    logic [31:0] second_source_operand;
  } mdu_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } mdu_gpr_t;

  typedef enum logic [1:0] {
    MDU_ST_IDLE,
    MDU_ST_MUL2,
    MDU_ST_DIV
  } mdu_state_t;

  typedef struct packed {
    mdu_state_t st;
    mdu_op_t op;
    logic is_signed;
    logic [31:0] upper_result_reg;
    logic [31:0] lower_result_reg;
    logic [63:0] part;
    logic [31:0] a_op;
    logic [15:0] b_hi;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] dvs;
    logic q_neg;
    logic r_neg;
    logic [5:0] cnt;
    logic gpr_pend;
    logic [31:0] gpr_data;
    logic gpr_valid;
    logic [31:0] gpr_out;
    logic div_done;
  } mdu_state_s_t;
endpackage

// ==== src/mdu_mul_div_unit.sv ====
// Multiply/divide unit beside the integer pipeline: 32x16 array, result pair.
// Assumes the integer pipeline holds a request while o_issue_stall is high.
module mdu_mul_div_unit (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire mdu_pkg::mdu_req_t i_req,
  output logic o_issue_stall,
  output mdu_pkg::mdu_gpr_t o_gpr,
  output logic o_div_done,
  output logic o_busy,
  output logic [31:0] o_upper_result,
  output logic [31:0] o_lower_result
);
  mdu_pkg::mdu_state_s_t s_reg;
  mdu_pkg::mdu_state_s_t s_next;

  // Second operand fits in 16 bits (signed or unsigned view)
  function automatic logic fits16(input logic [31:0] v, input logic sg);
    if (sg) begin
      fits16 = (v[31:15] == {17{v[15]}});
    end else begin
      fits16 = (v[31:16] == 16'h0000);
    end
  endfunction

  // One 32x16 pass: signed 33x17 product of extended pieces
  function automatic logic [63:0] pass32x16(input logic [31:0] a,
      input logic asg, input logic [15:0] b, input logic bsg);
    logic signed [32:0] ae;
    logic signed [16:0] be;
    logic signed [49:0] p;
    ae = {asg & a[31], a};
    be = {bsg & b[15], b};
    p = ae * be;
    pass32x16 = {{14{p[49]}}, p};
  endfunction

  // Dividend width class gives skipped iterations
  function automatic logic [5:0] div_skip(input logic [31:0] v,
      input logic sg);
    if (sg ? (v[31:7] == {25{v[7]}}) : (v[31:8] == 24'h0)) begin
      div_skip = mdu_pkg::MDU_SKIP_8;
    end else if (sg ? (v[31:15] == {17{v[15]}}) : (v[31:16] == 16'h0)) begin
      div_skip = mdu_pkg::MDU_SKIP_16;
    end else if (sg ? (v[31:23] == {9{v[23]}}) : (v[31:24] == 8'h0)) begin
      div_skip = mdu_pkg::MDU_SKIP_24;
    end else begin
      div_skip = mdu_pkg::MDU_SKIP_32;
    end
  endfunction

  logic [63:0] acc_in;
  logic [63:0] prod1;
  logic [63:0] prod_full;
  logic [63:0] prod2;
  logic [31:0] dvd_mag;
  logic [31:0] dvs_mag;
  logic [32:0] trial;
  logic [5:0] skip;
  logic narrow;
  logic take;

  // Stall: divide active blocks all issue, wide first pass blocks the next
  assign o_issue_stall = i_req.valid &&
      (s_reg.st != mdu_pkg::MDU_ST_IDLE);
  assign take = i_req.valid && !o_issue_stall;
  assign narrow = fits16(i_req.second_source_operand,
      i_req.is_signed);

  // Next-state logic; the unit never looks at the pipeline's own stall
  always_comb begin
    s_next = s_reg;
    s_next.div_done = 1'b0;
    s_next.gpr_valid = 1'b0;
    acc_in = {s_reg.upper_result_reg, s_reg.lower_result_reg};
    prod1 = pass32x16(i_req.first_source_operand, i_req.is_signed,
        i_req.second_source_operand[15:0],
        i_req.is_signed & narrow);
    // Second pass: upper half weighted by 2^16, low pass unsigned;
    // the shift pushes out 16 sign copies, so only 48 bits are kept
    prod2 = pass32x16(s_reg.a_op, s_reg.is_signed, s_reg.b_hi,
        s_reg.is_signed);
    prod_full = s_reg.part + {prod2[47:0], 16'h0000};
    dvd_mag = (i_req.is_signed && i_req.first_source_operand[31]) ?
        -i_req.first_source_operand : i_req.first_source_operand;
    dvs_mag = (i_req.is_signed && i_req.second_source_operand[31]) ?
        -i_req.second_source_operand : i_req.second_source_operand;
    skip = div_skip(i_req.first_source_operand, i_req.is_signed);
    trial = {s_reg.rem, s_reg.quo[31]} - {1'b0, s_reg.dvs};
    // Register-writing result leaves one stage after the product
    if (s_reg.gpr_pend) begin
      s_next.gpr_pend = 1'b0;
      s_next.gpr_valid = 1'b1;
      s_next.gpr_out = s_reg.gpr_data;
    end
    case (s_reg.st)
      mdu_pkg::MDU_ST_MUL2: begin
        s_next.st = mdu_pkg::MDU_ST_IDLE;
        if (s_reg.op == mdu_pkg::MDU_OP_MACC_ADD) begin
          {s_next.upper_result_reg, s_next.lower_result_reg} =
              acc_in + prod_full;
        end else if (s_reg.op == mdu_pkg::MDU_OP_MACC_SUB) begin
          {s_next.upper_result_reg, s_next.lower_result_reg} =
              acc_in - prod_full;
        end else begin
          {s_next.upper_result_reg, s_next.lower_result_reg} = prod_full;
        end
        if (s_reg.op == mdu_pkg::MDU_OP_MUL_GPR) begin
          s_next.gpr_pend = 1'b1;
          s_next.gpr_data = prod_full[31:0];
        end
      end
      mdu_pkg::MDU_ST_DIV: begin
        // Restoring step, one quotient bit each clock
        s_next.quo = {s_reg.quo[30:0], ~trial[32]};
        s_next.rem = trial[32] ? {s_reg.rem[30:0], s_reg.quo[31]} :
            trial[31:0];
        s_next.cnt = s_reg.cnt - mdu_pkg::MDU_CNT_ONE;
        if (s_reg.cnt == mdu_pkg::MDU_CNT_ONE) begin
          s_next.st = mdu_pkg::MDU_ST_IDLE;
          s_next.div_done = 1'b1;
          s_next.lower_result_reg = s_reg.q_neg ? -s_next.quo : s_next.quo;
          s_next.upper_result_reg = s_reg.r_neg ? -s_next.rem : s_next.rem;
        end
      end
      default: begin
      end
    endcase
    // Issue in idle; wide multiplies keep the array a second cycle
    if (take) begin
      s_next.op = i_req.op;
      s_next.is_signed = i_req.is_signed;
      if (i_req.op == mdu_pkg::MDU_OP_DIV) begin
        // Skipped dividend bits are preshifted out of the quotient register
        s_next.st = mdu_pkg::MDU_ST_DIV;
        s_next.quo = dvd_mag << skip;
        s_next.rem = mdu_pkg::MDU_ZERO32;
        s_next.dvs = dvs_mag;
        s_next.cnt = mdu_pkg::MDU_DIV_ITERS - skip;
        s_next.q_neg = i_req.is_signed & (i_req.first_source_operand[31] ^
            i_req.second_source_operand[31]);
        s_next.r_neg = i_req.is_signed & i_req.first_source_operand[31];
      end else if (narrow) begin
        if (i_req.op == mdu_pkg::MDU_OP_MACC_ADD) begin
          {s_next.upper_result_reg, s_next.lower_result_reg} = acc_in + prod1;
        end else if (i_req.op == mdu_pkg::MDU_OP_MACC_SUB) begin
          {s_next.upper_result_reg, s_next.lower_result_reg} = acc_in - prod1;
        end else begin
          {s_next.upper_result_reg, s_next.lower_result_reg} = prod1;
        end
        if (i_req.op == mdu_pkg::MDU_OP_MUL_GPR) begin
          s_next.gpr_pend = 1'b1;
          s_next.gpr_data = prod1[31:0];
        end
      end else begin
        s_next.st = mdu_pkg::MDU_ST_MUL2;
        s_next.part = pass32x16(i_req.first_source_operand, i_req.is_signed,
            i_req.second_source_operand[15:0], 1'b0);
        s_next.a_op = i_req.first_source_operand;
        s_next.b_hi = i_req.second_source_operand[31:16];
      end
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_gpr.valid = s_reg.gpr_valid;
  assign o_gpr.data = s_reg.gpr_out;
  assign o_div_done = s_reg.div_done;
  assign o_busy = (s_reg.st != mdu_pkg::MDU_ST_IDLE);
  assign o_upper_result = s_reg.upper_result_reg;
  assign o_lower_result = s_reg.lower_result_reg;

  // Assertions
  a_wide_two_pass: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      take && i_req.op != mdu_pkg::MDU_OP_DIV && !narrow |=>
      s_reg.st == mdu_pkg::MDU_ST_MUL2 ##1
      s_reg.st == mdu_pkg::MDU_ST_IDLE)
    else $error("wide multiply not two passes");
  a_wide_stall: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      s_reg.st == mdu_pkg::MDU_ST_MUL2 && i_req.valid |->
      o_issue_stall)
    else $error("back-to-back wide multiply not stalled");
  a_narrow_rate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      take && narrow && i_req.op != mdu_pkg::MDU_OP_DIV |=>
      !o_busy)
    else $error("narrow multiply blocked next issue");
  a_div_stall: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      s_reg.st == mdu_pkg::MDU_ST_DIV && i_req.valid |->
      o_issue_stall)
    else $error("issue not stalled during divide");
  a_div8_lat: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      take && i_req.op == mdu_pkg::MDU_OP_DIV &&
      skip == mdu_pkg::MDU_SKIP_8 |=> o_busy [*8] ##1 o_busy
      ##1 !o_busy && o_div_done)
    else $error("8-bit divide latency wrong");
  a_div32_lat: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      take && i_req.op == mdu_pkg::MDU_OP_DIV &&
      skip == mdu_pkg::MDU_SKIP_32 |=>
      !o_div_done [*8] ##25 o_div_done)
    else $error("32-bit divide latency wrong");
  a_gpr_lat: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      take && narrow && i_req.op == mdu_pkg::MDU_OP_MUL_GPR |=>
      ##1 o_gpr.valid && o_gpr.data == $past(prod1[31:0], 2))
    else $error("register multiply latency wrong");
  a_wmul_result: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      take && narrow && i_req.op == mdu_pkg::MDU_OP_WMUL |=>
      {o_upper_result, o_lower_result} == $past(prod1))
    else $error("widening product not in result pair");
  a_skip_cnt: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      take && i_req.op == mdu_pkg::MDU_OP_DIV |=>
      s_reg.cnt == mdu_pkg::MDU_DIV_ITERS - $past(skip))
    else $error("divide skip count wrong");

  c_wide: cover property (@(posedge i_mclk)
      s_reg.st == mdu_pkg::MDU_ST_MUL2);
  c_div_done: cover property (@(posedge i_mclk) o_div_done);
  c_gpr: cover property (@(posedge i_mclk) o_gpr.valid);
  c_stall: cover property (@(posedge i_mclk) o_issue_stall);
endmodule

// ==== test/mdu_tb_pipe.sv ====
// Integer pipeline model: issues queued requests, holds them while stalled.
// Assumes one clock; the bench fills the queues and reads back the notes.
module mdu_tb_pipe (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_issue_stall,
  output mdu_pkg::mdu_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  mdu_pkg::mdu_req_t req_q[$];
  logic [63:0] exp_q[$];
  int lat_q[$];
  int n_t[$];
  logic [63:0] n_exp[$];
  int n_lat[$];
  mdu_pkg::mdu_op_t n_op[$];
  logic [63:0] cur_exp = '0;
  int cur_lat = 0;
  int edges = 0;
  // Request stands until an edge sees no stall, then it is noted as taken
  always @(posedge i_mclk) begin
    edges <= edges + 1;
    if (i_sys_rst) begin
      o_req <= '0;
    end else if (!(o_req.valid && i_issue_stall)) begin
      if (o_req.valid) begin
        n_t.push_back(edges);
        n_exp.push_back(cur_exp);
        n_lat.push_back(cur_lat);
        n_op.push_back(o_req.op);
      end
      // Bubbles carry junk operands with valid low
      if (req_q.size() > 0) begin
        o_req <= req_q.pop_front();
        cur_exp <= exp_q.pop_front();
        cur_lat <= lat_q.pop_front();
      end else begin
        o_req <= '0;
      end
    end
  end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the multiply/divide unit.
// Assumes the pipeline model drives requests and notes when they are taken.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  mdu_pkg::mdu_req_t req;
  mdu_pkg::mdu_gpr_t gpr;
  mdu_pkg::mdu_op_t o;
  logic stall, done, busy, g, dn;
  logic [31:0] up, lo;
  logic [31:0] lfsr = 32'h8c963a7d;
  logic [63:0] acc = '0;
  logic [63:0] e;
  int miscompares = 0;
  int comparisons = 0;
  int rep_q[$];
  int t, rp, left;
  int pt = -1;
  mdu_mul_div_unit dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_req(req), .o_issue_stall(stall), .o_gpr(gpr), .o_div_done(done),
    .o_busy(busy), .o_upper_result(up), .o_lower_result(lo));
  mdu_tb_pipe pipe_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_issue_stall(stall), .o_req(req));
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  // Bench random source, one step per call
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string n, input logic [63:0] x,
                       input logic [63:0] s);
    comparisons++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Expected result and latency worked out from the operands and the running accumulator
  task automatic put(input mdu_pkg::mdu_op_t op, input logic sg,
                     input logic [31:0] a, input logic [31:0] b);
    logic [63:0] p;
    logic [63:0] ex;
    logic [31:0] x;
    logic wd;
    int lat;
    int rpt;
    lfsr = lfsr_next(lfsr);
    if (lfsr[3:0] == 4'h0 && rep_q.size() > 0) begin
      rep_q[rep_q.size() - 1] = 0;
      pipe_u.req_q.push_back({1'b0, op, sg, lfsr, ~lfsr});
      pipe_u.exp_q.push_back('0);
      pipe_u.lat_q.push_back(0);
    end
    p = (sg ? {{32{a[31]}}, a} : {32'h0, a}) *
        (sg ? {{32{b[31]}}, b} : {32'h0, b});
    wd = sg ? (b[31:15] != {17{b[15]}}) : (b[31:16] != 16'h0);
    lat = wd ? 2 : 1;
    rpt = wd ? 2 : 1;
    case (op)
      mdu_pkg::MDU_OP_WMUL: acc = p;
      mdu_pkg::MDU_OP_MACC_ADD: acc = acc + p;
      mdu_pkg::MDU_OP_MACC_SUB: acc = acc - p;
      default: acc = acc;
    endcase
    ex = acc;
    if (op == mdu_pkg::MDU_OP_MUL_GPR) begin
      // The register-writing multiply leaves its product in the pair too
      ex = {32'h0, p[31:0]};
      acc = p;
      lat = lat + 1;
    end
    if (op == mdu_pkg::MDU_OP_DIV) begin
      // Done comes 33 - skip edges after taking; next take on that cycle
      lat = 33;
      for (int j = 2; j >= 0; j--) begin
        x = sg ? 32'($signed(a << (24 - 8 * j)) >>> (24 - 8 * j))
               : (a << (24 - 8 * j)) >> (24 - 8 * j);
        if (x === a) begin
          lat = 10 + 8 * j;
        end
      end
      rpt = lat;
      ex = sg ? {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))}
              : {a % b, a / b};
      acc = ex;
    end
    rep_q.push_back(rpt);
    pipe_u.req_q.push_back({1'b1, op, sg, a, b});
    pipe_u.exp_q.push_back(ex);
    pipe_u.lat_q.push_back(lat);
  endtask
  // Each note is due a fixed number of cycles after its taking edge
  always @(negedge i_mclk) begin
    g = gpr.valid;
    dn = done;
    // A late note still comes off, so a slip shows as a mismatch, not a hang
    while (pipe_u.n_t.size() > 0 &&
           pipe_u.edges - pipe_u.n_t[0] >= pipe_u.n_lat[0]) begin
      t = pipe_u.n_t.pop_front();
      e = pipe_u.n_exp.pop_front();
      o = pipe_u.n_op.pop_front();
      void'(pipe_u.n_lat.pop_front());
      if (pt >= 0 && rp > 0) check("repeat", 64'(rp), 64'(t - pt));
      rp = rep_q.pop_front();
      pt = t;
      if (o == mdu_pkg::MDU_OP_MUL_GPR) begin
        check("gpr", {1'b1, e[31:0]}, {g, gpr.data});
        g = 1'b0;
      end else begin
        check("pair", e, {up, lo});
      end
      if (o == mdu_pkg::MDU_OP_DIV) begin
        check("done", 64'h1, {63'h0, dn});
        dn = 1'b0;
      end
    end
    if (!i_sys_rst) check("stray", 64'h0, {62'h0, g, dn});
  end
  initial begin
    #(8 * 30000);
    miscompares++;
    end_sim();
  end
  // Sixty rounds of every op on random operands, then drain and check
  initial begin
    repeat (5) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(negedge i_mclk);
    check("rst", 64'h0, {up, lo});
    for (int i = 0; i < 60; i++) begin
      lfsr = lfsr_next(lfsr);
      put(mdu_pkg::MDU_OP_WMUL, i[0], lfsr, 32'h0000_7fff);
      put(mdu_pkg::MDU_OP_WMUL, i[0], ~lfsr, i < 2 ? 32'hffff_8000 : lfsr);
      put(mdu_pkg::MDU_OP_MACC_ADD, i[0], lfsr, 32'h1234_5678);
      put(mdu_pkg::MDU_OP_MACC_SUB, i[0], ~lfsr, 32'h8000_0000);
      put(mdu_pkg::MDU_OP_MUL_GPR, i[0], lfsr, {16'h0, lfsr[14:0], 1'b1});
      put(mdu_pkg::MDU_OP_MUL_GPR, i[0], ~lfsr, lfsr | 32'h0003_0000);
      put(mdu_pkg::MDU_OP_MUL_GPR, i[0], lfsr, lfsr | 32'h0100_0000);
      for (int k = 0; k < 4; k++) begin
        put(mdu_pkg::MDU_OP_DIV, i[0], (((lfsr >> k) & ((32'h80 << (8 * k))
          - 32'h1)) | (32'h40 << (8 * k))) ^ {32{i[0] & lfsr[k]}},
          {16'h0, lfsr[31:17], 1'b1});
      end
    end
    for (int w = 0; w < 20000 && pipe_u.n_t.size() +
         pipe_u.req_q.size() + 32'(req.valid) > 0; w++) begin
      @(posedge i_mclk);
    end
    repeat (40) @(posedge i_mclk);
    // Anything still queued or unanswered here means the unit hung
    left = pipe_u.n_t.size() + pipe_u.req_q.size();
    check("drain", 64'h0, 64'(left));
    end_sim();
  end
endmodule
